// ==== core/clk_strap_consts.vh ====
// Constants for the power-up clock ratio strap decoder
`ifndef CLK_STRAP_CONSTS_VH
`define CLK_STRAP_CONSTS_VH

// ============================================================
// Register byte offsets
`define REG_CTRL_OFS        8'h00
`define REG_PLAT_OFS        8'h04
`define REG_CORE0_OFS       8'h08
`define REG_CORE1_OFS       8'h0C
`define REG_MEM_OFS         8'h10
`define REG_STATUS_OFS      8'h14
`define REG_STRAPS_OFS      8'h18

// ============================================================
// Field positions
`define CTRL_RESAMPLE_BIT   0
`define CTRL_MCLK_EN_BIT    1
`define STAT_LATCHED_BIT    0
`define STAT_PLAT_BAD_BIT   1
`define STAT_CORE0_BAD_BIT  2
`define STAT_CORE1_BAD_BIT  3
`define STAT_SYNC_BIT       4
`define STAT_CFG_BAD_BIT    5
`define RATIO_NUM_LSB       0
`define RATIO_DEN_LSB       8

// ============================================================
// Reset values
`define CTRL_RESET          2'h2

// ============================================================
// Strap codes
`define MEM_SYNC_CODE       3'h7
`define CORE_RSVD_MAX       3'h2
`define PLAT_RSVD_MIN       3'h6

// ============================================================
// Timing: cycles counted after reset or resample before latching
`define SETTLE_CYCLES       4'h8

`endif

// ==== core/clock_ratio_strap_decoder.v ====
// Power-up strap sampling, ratio decode and memory clock mode logic
//
// Register access over Wishbone and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "clk_strap_consts.vh"

// How it works
// - Platform clock equals core complex bus clock
// - Platform ratio from three strap bits
// - Platform codes 4,5,6,8,10,12; 110/111 reserved
// - Each core ratio decoded independently
// - Core0 code from msb, mid, lsb straps
// - Core codes 3:2..7:2; 000-010 reserved
// - Core1 uses same table, own straps
// - Sync mode: memory clock half platform
// - Async mode: clock from memory PLL reference
// - Memory clock outputs at half data rate; logic gives half the PLL reference in async mode
// - Memory ratio codes 3..14; 111 is sync
// - Both memory controllers share one mode
module clock_ratio_strap_decoder #(
	parameter MCK_OUTS = 6
) (
	input  wire                clk_i,
	input  wire                rst_i,
	input  wire [2:0]          platform_ratio_strap_i,
	input  wire                core0_ratio_strap_msb_i,
	input  wire                core0_ratio_strap_mid_i,
	input  wire                core0_ratio_strap_lsb_i,
	input  wire                core1_ratio_strap_msb_i,
	input  wire                core1_ratio_strap_mid_i,
	input  wire                core1_ratio_strap_lsb_i,
	input  wire                memory_ratio_strap_msb_i,
	input  wire                memory_ratio_strap_mid_i,
	input  wire                memory_ratio_strap_lsb_i,
	input  wire                memory_pll_reference_clock_i,
	input  wire                wb_cyc_i,
	input  wire                wb_stb_i,
	input  wire                wb_we_i,
	input  wire [7:0]          wb_adr_i,
	input  wire [3:0]          wb_sel_i,
	input  wire [31:0]         wb_dat_i,
	output reg  [31:0]         wb_dat_o,
	output reg                 wb_ack_o,
	output wire                platform_bus_clock_en_o,
	output reg  [MCK_OUTS-1:0] memory_bus_clock_out_o,
	output wire                memory_sync_mode_o,
	output wire                config_invalid_o
);

	// ============================================================
	// Strap synchronisers: three stages, change once stages 2 and 3 agree
	reg  [11:0] s1_reg;
	reg  [11:0] s2_reg;
	reg  [11:0] s3_reg;
	reg  [11:0] stable_reg;
	reg         mclk_s1_reg;
	reg         mclk_s2_reg;
	reg         mclk_s3_reg;
	wire [11:0] strap_raw;

	assign strap_raw = {platform_ratio_strap_i,
		core0_ratio_strap_msb_i, core0_ratio_strap_mid_i, core0_ratio_strap_lsb_i,
		core1_ratio_strap_msb_i, core1_ratio_strap_mid_i, core1_ratio_strap_lsb_i,
		memory_ratio_strap_msb_i, memory_ratio_strap_mid_i, memory_ratio_strap_lsb_i};

	// Sync chains; stable copy updates only on agreement of later stages
	always @(posedge clk_i) begin
		if (rst_i) begin
			s1_reg      <= 12'h000;
			s2_reg      <= 12'h000;
			s3_reg      <= 12'h000;
			stable_reg  <= 12'h000;
			mclk_s1_reg <= 1'b0;
			mclk_s2_reg <= 1'b0;
			mclk_s3_reg <= 1'b0;
		end else begin
			s1_reg      <= strap_raw;
			s2_reg      <= s1_reg;
			s3_reg      <= s2_reg;
			mclk_s1_reg <= memory_pll_reference_clock_i;
			mclk_s2_reg <= mclk_s1_reg;
			mclk_s3_reg <= mclk_s2_reg;
			if (s2_reg == s3_reg) begin
				stable_reg <= s3_reg;
			end
		end
	end

	// ============================================================
	// Latch after the straps settle following reset release
	reg  [3:0]  settle_reg;
	reg         latched_reg;
	reg  [2:0]  plat_code_reg;
	reg  [2:0]  core0_code_reg;
	reg  [2:0]  core1_code_reg;
	reg  [2:0]  mem_code_reg;
	reg  [1:0]  ctrl_reg;
	wire        resample_req;

	assign resample_req = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0]
		& (wb_adr_i == `REG_CTRL_OFS) & wb_dat_i[`CTRL_RESAMPLE_BIT];

	// Codes held until next reset or CTRL resample write; sampling is clocked, never async
	always @(posedge clk_i) begin
		if (rst_i) begin
			settle_reg     <= 4'h0;
			latched_reg    <= 1'b0;
			plat_code_reg  <= 3'h0;
			core0_code_reg <= 3'h0;
			core1_code_reg <= 3'h0;
			mem_code_reg   <= 3'h0;
		end else if (resample_req) begin
			settle_reg  <= 4'h0;
			latched_reg <= 1'b0;
		end else if (!latched_reg) begin
			if (settle_reg == `SETTLE_CYCLES) begin
				latched_reg    <= 1'b1;
				plat_code_reg  <= stable_reg[11:9];
				core0_code_reg <= stable_reg[8:6];
				core1_code_reg <= stable_reg[5:3];
				mem_code_reg   <= stable_reg[2:0];
			end else begin
				settle_reg <= settle_reg + 4'h1;
			end
		end
	end

	// ============================================================
	// Ratio decode: numerator / denominator pairs
	reg  [7:0]  plat_num;
	reg  [7:0]  core0_num;
	reg  [7:0]  core1_num;
	reg  [7:0]  mem_num;
	wire        plat_bad;
	wire        core0_bad;
	wire        core1_bad;
	wire        mem_sync;

	// Platform to reference clock multiplier
	always @* begin
		case (plat_code_reg)
		3'h0: plat_num = 8'h04;
		3'h1: plat_num = 8'h05;
		3'h2: plat_num = 8'h06;
		3'h3: plat_num = 8'h08;
		3'h4: plat_num = 8'h0A;
		3'h5: plat_num = 8'h0C;
		default: plat_num = 8'h00;
		endcase
	end

	// Core ratios, numerator over 2: 3:2 is 3, 2:1 is 4
	always @* begin
		case (core0_code_reg)
		3'h3: core0_num = 8'h03;
		3'h4: core0_num = 8'h04;
		3'h5: core0_num = 8'h05;
		3'h6: core0_num = 8'h06;
		3'h7: core0_num = 8'h07;
		default: core0_num = 8'h00;
		endcase
		case (core1_code_reg)
		3'h3: core1_num = 8'h03;
		3'h4: core1_num = 8'h04;
		3'h5: core1_num = 8'h05;
		3'h6: core1_num = 8'h06;
		3'h7: core1_num = 8'h07;
		default: core1_num = 8'h00;
		endcase
	end

	// Memory data rate to memory PLL reference ratio
	always @* begin
		case (mem_code_reg)
		3'h0: mem_num = 8'h03;
		3'h1: mem_num = 8'h04;
		3'h2: mem_num = 8'h06;
		3'h3: mem_num = 8'h08;
		3'h4: mem_num = 8'h0A;
		3'h5: mem_num = 8'h0C;
		3'h6: mem_num = 8'h0E;
		default: mem_num = 8'h00;
		endcase
	end

	assign plat_bad  = (plat_code_reg >= `PLAT_RSVD_MIN);
	assign core0_bad = (core0_code_reg <= `CORE_RSVD_MAX);
	assign core1_bad = (core1_code_reg <= `CORE_RSVD_MAX);
	assign mem_sync  = (mem_code_reg == `MEM_SYNC_CODE);

	assign memory_sync_mode_o = latched_reg & mem_sync;
	assign config_invalid_o   = latched_reg & (plat_bad | core0_bad | core1_bad);

	// ============================================================
	// Platform clock enable: same clock drives platform and core bus
	assign platform_bus_clock_en_o = latched_reg;

	// ============================================================
	// Memory bus clock: one shared toggle feeds all outputs
	reg  mck_reg;
	wire mclk_rise;

	// Edge of the memory PLL clock, read only from later stages
	assign mclk_rise = mclk_s2_reg & ~mclk_s3_reg;

	// Both controllers share one mode, so a single toggle suffices
	always @(posedge clk_i) begin
		if (rst_i) begin
			mck_reg <= 1'b0;
		end else if (!latched_reg || !ctrl_reg[`CTRL_MCLK_EN_BIT]) begin
			mck_reg <= 1'b0;
		end else if (mem_sync) begin
			mck_reg <= ~mck_reg;
		end else if (mclk_rise) begin
			mck_reg <= ~mck_reg;
		end
	end

	// Fan out to every output; half clk_i in sync mode, half the PLL reference in async mode
	genvar gi;
	generate
		for (gi = 0; gi < MCK_OUTS; gi = gi + 1) begin : g_mck
			always @(posedge clk_i) begin
				if (rst_i) begin
					memory_bus_clock_out_o[gi] <= 1'b0;
				end else begin
					memory_bus_clock_out_o[gi] <= mck_reg;
				end
			end
		end
	endgenerate

	// ============================================================
	// Wishbone classic slave: ack one cycle after strobe
	wire        wb_req;
	reg  [31:0] rd_data;

	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

	// Read mux; unmapped offsets read zero
	always @* begin
		case (wb_adr_i)
		`REG_CTRL_OFS:   rd_data = {30'h00000000, ctrl_reg};
		`REG_PLAT_OFS:   rd_data = {16'h0000, 8'h01, plat_num};
		`REG_CORE0_OFS:  rd_data = {16'h0000, 8'h02, core0_num};
		`REG_CORE1_OFS:  rd_data = {16'h0000, 8'h02, core1_num};
		`REG_MEM_OFS:    rd_data = {16'h0000, 8'h01, mem_num};
		`REG_STATUS_OFS: rd_data = {26'h0000000, config_invalid_o, mem_sync,
			core1_bad, core0_bad, plat_bad, latched_reg};
		`REG_STRAPS_OFS: rd_data = {20'h00000, plat_code_reg, core0_code_reg,
			core1_code_reg, mem_code_reg};
		default:         rd_data = 32'h00000000;
		endcase
	end

	// Ack, read data capture and control register write
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			ctrl_reg <= `CTRL_RESET;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				wb_dat_o <= rd_data;
			end
			if (wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `REG_CTRL_OFS)) begin
				ctrl_reg <= {wb_dat_i[`CTRL_MCLK_EN_BIT], 1'b0};
			end
		end
	end

endmodule // clock_ratio_strap_decoder

// ==== sim/strap_board.sv ====
// Board strap resistors and memory reference clock model
`timescale 1ns/100ps
module strap_board (
	input  wire [11:0] codes_i,
	output wire [11:0] straps_o,
	output reg         pll_clk_o
);
	// Straps are always pulled to an explicit level, never left floating
	// The board picks mode and ratios; keeping speed grades is its duty
	assign straps_o = codes_i;
	// Free-running reference, well under a quarter of the system clock
	initial pll_clk_o = 1'b0;
	always #185 pll_clk_o = ~pll_clk_o;
endmodule // strap_board

// ==== sim/strap_decoder_assertions.sv ====
// Port-level checker for the strap decoder
`timescale 1ns/100ps
module strap_decoder_checker #(
	parameter MCK_OUTS = 6
) (
	input wire                clk_i,
	input wire                rst_i,
	input wire                wb_cyc_i,
	input wire                wb_stb_i,
	input wire                wb_ack_o,
	input wire                wb_we_i,
	input wire [7:0]          wb_adr_i,
	input wire [3:0]          wb_sel_i,
	input wire [31:0]         wb_dat_i,
	input wire                memory_pll_reference_clock_i,
	input wire                platform_bus_clock_en_o,
	input wire [MCK_OUTS-1:0] memory_bus_clock_out_o,
	input wire                memory_sync_mode_o,
	input wire                config_invalid_o
);
	// ====
	// One domain, so clock and reset are given once
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Shadow of the memory clock enable, so clock checks pause while it is off
	reg mclk_on;
	always @(posedge clk_i) begin
		if (rst_i) begin
			mclk_on <= 1'b1;
		end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
			&& (wb_adr_i == 8'h00)) begin
			mclk_on <= wb_dat_i[1];
		end
	end
	property p_ack_answer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("ack late");
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_rst_clear; disable iff (1'b0) rst_i |=> !platform_bus_clock_en_o
		&& !memory_sync_mode_o && !config_invalid_o && !wb_ack_o; endproperty
	a_rst_clear: assert property (p_rst_clear) else $error("reset state");
	property p_latch_wait; $fell(rst_i) |-> !platform_bus_clock_en_o [*8]; endproperty
	a_latch_wait: assert property (p_latch_wait) else $error("latched early");
	property p_latch_due; $fell(rst_i) |-> ##[1:40] platform_bus_clock_en_o; endproperty
	a_latch_due: assert property (p_latch_due) else $error("never latched");
	property p_inval; config_invalid_o |-> platform_bus_clock_en_o; endproperty
	a_inval: assert property (p_inval) else $error("flag unlatched");
	property p_sync; memory_sync_mode_o |-> platform_bus_clock_en_o; endproperty
	a_sync: assert property (p_sync) else $error("mode unlatched");
	property p_same; memory_bus_clock_out_o == {MCK_OUTS{memory_bus_clock_out_o[0]}}; endproperty
	a_same: assert property (p_same) else $error("clocks differ");
	property p_half; memory_sync_mode_o && $past(memory_sync_mode_o, 2)
		&& mclk_on && $past(mclk_on, 2)
		|-> memory_bus_clock_out_o[0] != $past(memory_bus_clock_out_o[0]); endproperty
	a_half: assert property (p_half) else $error("sync clock stuck");
	property p_follow; platform_bus_clock_en_o && !memory_sync_mode_o && mclk_on
		&& $rose(memory_pll_reference_clock_i)
		|-> ##[1:6] memory_bus_clock_out_o[0] != $past(memory_bus_clock_out_o[0]); endproperty
	a_follow: assert property (p_follow) else $error("async clock stuck");
endmodule // strap_decoder_checker

bind clock_ratio_strap_decoder strap_decoder_checker #(.MCK_OUTS(MCK_OUTS)) i_chk (
	.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
	.memory_pll_reference_clock_i,
	.platform_bus_clock_en_o, .memory_bus_clock_out_o, .memory_sync_mode_o, .config_invalid_o);

// ==== sim/tb_top.sv ====
// Self-checking bench for the strap decoder
`timescale 1ns/100ps
module tb_top;
	reg          clk_i = 1'b0;
	reg          rst_i = 1'b1;
	reg          cyc = 1'b0;
	reg          we = 1'b0;
	reg  [7:0]   adr = 8'h00;
	reg  [31:0]  wdat = 32'h0;
	reg  [11:0]  codes = 12'h000;
	wire [11:0]  s;
	wire [31:0]  rdat;
	wire [5:0]   mck;
	wire         ack, pll, en, sync, inval;
	logic [31:0] exp_q [$];
	logic [31:0] e [0:7];
	logic [7:0]  pn [0:7] = '{8'h04, 8'h05, 8'h06, 8'h08, 8'h0A, 8'h0C, 8'h00, 8'h00};
	logic [7:0]  mn [0:7] = '{8'h03, 8'h04, 8'h06, 8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h00};
	// Core ratios in halves: 3:2 is 3, 7:2 is 7, reserved codes 0
	logic [7:0]  cn [0:7] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07};
	reg  [5:0]   mk;
	integer      errors = 0;
	integer      compares = 0;
	integer      seed = 32'h88E4;
	integer      i, n;
	reg  [7:0]   k;
	reg  [2:0]   p, c0, c1, m, bad;

	always #25 clk_i = ~clk_i;

	strap_board i_strap_board (.codes_i(codes), .straps_o(s), .pll_clk_o(pll));
	// Strap fields packed plat, core0, core1, memory, msb first
	clock_ratio_strap_decoder i_clock_ratio_strap_decoder (
		.clk_i(clk_i), .rst_i(rst_i), .platform_ratio_strap_i(s[11:9]),
		.core0_ratio_strap_msb_i(s[8]), .core0_ratio_strap_mid_i(s[7]),
		.core0_ratio_strap_lsb_i(s[6]), .core1_ratio_strap_msb_i(s[5]),
		.core1_ratio_strap_mid_i(s[4]), .core1_ratio_strap_lsb_i(s[3]),
		.memory_ratio_strap_msb_i(s[2]), .memory_ratio_strap_mid_i(s[1]),
		.memory_ratio_strap_lsb_i(s[0]), .memory_pll_reference_clock_i(pll),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .platform_bus_clock_en_o(en),
		.memory_bus_clock_out_o(mck), .memory_sync_mode_o(sync), .config_invalid_o(inval));

	task end_of_test;
		begin
			if (errors == 0 && compares > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask

	task check(input string name, input [31:0] seen, input [31:0] want);
		begin
			compares = compares + 1;
			if (seen !== want) begin
				errors = errors + 1;
				$display("Error %s expected %h seen %h", name, want, seen);
			end
		end
	endtask

	// ====
	// Wishbone classic cycle; reads leave their expectation in the queue
	task bus(input w, input [7:0] a, input [31:0] d, input [31:0] x);
		integer t;
		begin
			if (!w)
				exp_q.push_back(x);
			cyc <= 1'b1;
			we <= w;
			adr <= a;
			wdat <= d;
			t = 0;
			@(posedge clk_i);
			while (ack !== 1'b1) begin
				t = t + 1;
				if (t > 20) begin
					errors = errors + 1;
					end_of_test;
				end
				@(posedge clk_i);
			end
			cyc <= 1'b0;
			@(posedge clk_i);
		end
	endtask

	// Bounded wait for the straps to be latched
	task wait_latch;
		integer t;
		begin
			for (t = 0; en !== 1'b1; t = t + 1) begin
				if (t > 60) begin
					errors = errors + 1;
					end_of_test;
				end
				@(posedge clk_i);
			end
		end
	endtask

	// Scoreboard: every read answer is matched against the oldest note
	always @(posedge clk_i)
		if (ack === 1'b1 && we === 1'b0)
			check("wb_dat_o", rdat, exp_q.pop_front());

	initial begin
		repeat (13) @(posedge clk_i);
		// Every pass retakes random straps, reserved codes included; even passes use sync mode
		for (i = 0; i < 24; i = i + 1) begin
			n = $random(seed);
			codes <= {n[11:3], i[0] ? n[2:0] : 3'h7};
			rst_i <= 1'b1;
			repeat (3) @(posedge clk_i);
			rst_i <= 1'b0;
			wait_latch;
			{p, c0, c1, m} = codes;
			bad = {c1 < 3'h3, c0 < 3'h3, p > 3'h5};
			e[0] = 32'h2;
			e[1] = {16'h0, 8'h01, pn[p]};
			e[2] = {16'h0, 8'h02, cn[c0]};
			e[3] = {16'h0, 8'h02, cn[c1]};
			e[4] = {16'h0, 8'h01, mn[m]};
			e[5] = {26'h0, |bad, m == 3'h7, bad, 1'b1};
			e[6] = {20'h0, codes};
			e[7] = 32'h0;
			check("enable", en, 1'b1);
			check("sync", sync, m == 3'h7);
			check("invalid", inval, |bad);
			// Writes hit read-only and unmapped places too; only CTRL may change
			for (k = 8'h00; k < 8'h08; k = k + 8'h01) begin
				bus(1'b1, k << 2, (k == 8'h00) ? 32'h2 : $random(seed), 32'h0);
				bus(1'b0, k << 2, 32'h0, e[k]);
			end
			if (m == 3'h7) begin
				// Sync clock flips every cycle and stops while disabled
				mk = ~mck;
				@(posedge clk_i);
				check("mclk_sync", mck, mk);
				bus(1'b1, 8'h00, 32'h0, 32'h0);
				repeat (3) @(posedge clk_i);
				check("mclk_off", mck, 6'h00);
				bus(1'b1, 8'h00, 32'h2, 32'h0);
				// Moved straps stay unseen until a resample retakes them
				codes <= ~codes;
				bus(1'b0, 8'h18, 32'h0, e[6]);
				bus(1'b1, 8'h00, 32'h3, 32'h0);
				wait_latch;
				bus(1'b0, 8'h18, 32'h0, {20'h0, codes});
				check("sync_after", sync, 1'b0);
			end
		end
		end_of_test;
	end
endmodule // tb_top
